// file: i2c_target_pkg.sv
// constants, register map and state encodings for the i2c target block
package i2c_target_pkg;

   // register indices; byte address is four times the index
   localparam logic [3:0] IDX_CTRLR_CTRL   = 4'h3;
   localparam logic [3:0] IDX_CONTROL      = 4'h9;
   localparam logic [3:0] IDX_CMD_CTRL     = 4'ha;
   localparam logic [3:0] IDX_STATUS       = 4'hb;
   localparam logic [3:0] IDX_ADDRESS      = 4'hc;
   localparam logic [3:0] IDX_DATA         = 4'hd;

   // target_control fields
   localparam int CTL_BYTE_IRQ_EN  = 7;
   localparam int CTL_AS_IRQ_EN    = 6;
   localparam int CTL_STOP_DET_EN  = 5;
   localparam int CTL_PROMISC_EN   = 2;
   localparam int CTL_AUTO_ACK_EN  = 1;
   localparam int CTL_ENABLE       = 0;
   localparam logic [7:0] CTL_WMASK = 8'he7;

   // target_command_ctrl fields
   localparam int CMD_ACK_SEL      = 2;
   localparam logic [1:0] CMD_IDLE     = 2'h0;
   localparam logic [1:0] CMD_RESERVED = 2'h1;
   localparam logic [1:0] CMD_FINISH   = 2'h2;
   localparam logic [1:0] CMD_RESPOND  = 2'h3;

   // target_status fields
   localparam int ST_BYTE_DONE     = 7;
   localparam int ST_ADDR_STOP     = 6;
   localparam int ST_STRETCH       = 5;
   localparam int ST_LAST_ACK      = 4;
   localparam int ST_CONFLICT      = 3;
   localparam int ST_ILLEGAL       = 2;
   localparam int ST_DIR           = 1;
   localparam int ST_CAUSE         = 0;

   // controller_control field
   localparam int CC_ENABLE        = 0;

   localparam logic       CAUSE_STOP   = 1'b0;
   localparam logic       CAUSE_ADDR   = 1'b1;
   localparam logic [6:0] GENCALL_ADDR = 7'h00;
   localparam logic [3:0] BYTE_BITS    = 4'h8;
   localparam logic [7:0] RESET_BYTE   = 8'h00;

   // stop and bus-error detection need this many clocks per scl period
   localparam int MIN_CLK_PER_SCL = 4;

   typedef enum logic [3:0] {
      TS_IDLE,
      TS_ADDR,
      TS_ADDR_HOLD,
      TS_ACK,
      TS_RX,
      TS_RX_HOLD,
      TS_TX,
      TS_TX_ACK,
      TS_TX_HOLD
   } tstate_t;

   typedef enum logic [1:0] {
      NX_IDLE,
      NX_RX,
      NX_TX_EVENT
   } next_t;

endpackage

// file: i2c_target.sv
// i2c target control, command and status logic with avalon-mm registers
//
// Behaviour
// [R1] addr/stop irq only when its enable, its flag and global enable are set
// [R2] stop and address events share one flag and one interrupt line
// [R3] stop sets addr/stop flag only with stop detection enabled
// [R4] promiscuous mode accepts every address, else the target address is used
// [R5] auto-ack mode: command or data access resumes; otherwise wait for command (address and receive holds resume on data read, not write)
// [R6] target runs only while its enable bit is one
// [R7] ack select 0 acks, 1 nacks; used on data read or command
// [R8] command field is a write-only strobe reading zero; 0 idle, 1 reserved
// [R9] finish command: write acks then waits start; read just waits start
// [R10] respond after address: ack, then receive byte or raise data event
// [R11] respond after data: write acks and receives; read sends byte
// [R12] ack select written with a command is updated before the command
// [R13] byte-done flag sets on byte completion, also after a collision abort
// [R14] both flags clear on data register access or finish/respond command write
// [R15] addr/stop flag sets on address match or enabled stop
// [R16] scl held low and stretch status set on address or data event
// [R17] last-ack status holds the controller's latest ack bit
// [R18] conflict sets on lost high data bit or lost nack after match
// [R19] conflict clears on software write one and on any start
// [R20] illegal start/stop sets error with controller enabled; write one clears
// [R21] direction reflects read/write bit of last matched address
// [R22] cause bit: 0 for stop, 1 for address
// [R23] byte-done irq only when its enable, its flag and global enable are set
// [R24] match compares received address with upper seven target address bits
// [R25] reserved command code does nothing, like the idle code
//
// The Avalon-MM interface to the registers is this design's own decision.
`timescale 1ns/1ps
module i2c_target
   import i2c_target_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        reset,
   input  wire logic [5:0]  address,
   input  wire logic        read,
   input  wire logic        write,
   input  wire logic [31:0] writedata,
   input  wire logic [3:0]  byteenable,
   output      logic [31:0] readdata,
   output      logic        waitrequest,
   input  wire logic        scl_in,
   input  wire logic        sda_in,
   output      logic        scl_oe,
   output      logic        sda_oe,
   input  wire logic        global_irq_en,
   output      logic        irq_byte_done,
   output      logic        irq_addr_stop
);

   typedef struct packed {
      tstate_t    state;
      next_t      after_ack;
      logic       ack_from_addr;
      logic       scl_m;
      logic       scl_s;
      logic       scl_p;
      logic       sda_m;
      logic       sda_s;
      logic       sda_p;
      logic [7:0] ctrl;
      logic       ack_sel;
      logic       ctrlr_en;
      logic [7:0] addr_reg;
      logic [7:0] data_reg;
      logic [7:0] shreg;
      logic [3:0] bit_cnt;
      logic       just_started;
      logic       byte_done;
      logic       addr_stop;
      logic       last_ack;
      logic       conflict;
      logic       illegal;
      logic       dir;
      logic       cause;
      logic       scl_oe;
      logic       sda_oe;
      logic       wait_n;
      logic [7:0] rdata;
      logic       irq_bd;
      logic       irq_as;
   } st_t;

   st_t q;
   st_t d;

   function automatic logic addr_match(input logic [6:0] rx,
                                       input logic [7:0] own,
                                       input logic       promisc);
      addr_match = promisc || (rx == own[7:1]) ||
                   (own[0] && (rx == GENCALL_ADDR));
   endfunction

   // up to the end of the first scl pulse of a data byte a stop or start is the
   // normal frame end; in the address byte it is still a violation
   function automatic logic in_byte(input tstate_t s,
                                    input logic [3:0] cnt);
      in_byte = (cnt != 4'h0) && (cnt != BYTE_BITS) &&
                ((s == TS_ADDR) ||
                 (((s == TS_RX) || (s == TS_TX)) && (cnt != 4'h1)));
   endfunction

   logic       req;
   logic       done;
   logic [3:0] idx;
   logic       lane0;
   logic [7:0] wbyte;
   logic       cmd_wr;
   logic [1:0] cmd;
   logic       ack_now;
   logic       data_rd;
   logic       data_wr;
   logic       smart;
   logic       rise;
   logic       fall;
   logic       start_c;
   logic       stop_c;

   always_comb
   begin
      d       = q;
      req     = read || write;
      done    = req && !q.wait_n;
      idx     = address[5:2];
      lane0   = byteenable[0] && (address[1:0] == 2'h0);
      wbyte   = writedata[7:0];
      smart   = q.ctrl[CTL_AUTO_ACK_EN];
      cmd_wr  = done && write && lane0 && (idx == IDX_CMD_CTRL);
      cmd     = wbyte[1:0];
      data_rd = done && read && (idx == IDX_DATA);
      data_wr = done && write && lane0 && (idx == IDX_DATA);
      ack_now = q.ack_sel;

      // pin synchronisers
      d.scl_m = scl_in;
      d.scl_s = q.scl_m;
      d.scl_p = q.scl_s;
      d.sda_m = sda_in;
      d.sda_s = q.sda_m;
      d.sda_p = q.sda_s;
      rise    = q.scl_s && !q.scl_p;
      fall    = !q.scl_s && q.scl_p;
      start_c = q.scl_s && q.scl_p && q.sda_p && !q.sda_s;
      stop_c  = q.scl_s && q.scl_p && !q.sda_p && q.sda_s;

      // bus slave: one wait cycle, then the access completes
      if (req && q.wait_n)
      begin
         d.wait_n = 1'b0;
         if (read)
         begin
            if (address[1:0] != 2'h0)
               d.rdata = RESET_BYTE;
            else if (idx == IDX_CONTROL)
               d.rdata = q.ctrl;
            else if (idx == IDX_CMD_CTRL)
               d.rdata = {5'h00, q.ack_sel, 2'h0}; // see [R8]
            else if (idx == IDX_STATUS)
               d.rdata = {q.byte_done, q.addr_stop, q.scl_oe, q.last_ack,
                          q.conflict, q.illegal, q.dir, q.cause};
            else if (idx == IDX_ADDRESS)
               d.rdata = q.addr_reg;
            else if (idx == IDX_DATA)
               d.rdata = q.data_reg;
            else if (idx == IDX_CTRLR_CTRL)
               d.rdata = {7'h00, q.ctrlr_en};
            else
               d.rdata = RESET_BYTE;
         end
      end
      else if (done)
      begin
         d.wait_n = 1'b1;
         if (write && lane0)
         begin
            if (idx == IDX_CONTROL)
               d.ctrl = wbyte & CTL_WMASK;
            else if (idx == IDX_CMD_CTRL)
            begin
               d.ack_sel = wbyte[CMD_ACK_SEL];
               ack_now   = wbyte[CMD_ACK_SEL]; // see [R12]
            end
            else if (idx == IDX_STATUS)
            begin
               if (wbyte[ST_CONFLICT])
                  d.conflict = 1'b0; // see [R19]
               if (wbyte[ST_ILLEGAL])
                  d.illegal = 1'b0; // see [R20]
            end
            else if (idx == IDX_ADDRESS)
               d.addr_reg = wbyte;
            else if (idx == IDX_DATA)
               d.data_reg = wbyte;
            else if (idx == IDX_CTRLR_CTRL)
               d.ctrlr_en = wbyte[CC_ENABLE];
         end
      end

      // flag clearing comes first so that a same-cycle event wins
      if ((cmd_wr && (cmd == CMD_FINISH || cmd == CMD_RESPOND)) ||
          data_rd || data_wr)
      begin
         d.byte_done = 1'b0; // see [R14]
         d.addr_stop = 1'b0;
      end

      // software resumes a held transfer; the idle and reserved codes
      // fall through untouched
      case (q.state) // see [R25]
         TS_ADDR_HOLD:
         begin
            if ((cmd_wr && cmd == CMD_RESPOND) || (smart && data_rd))
            begin
               d.state         = TS_ACK; // see [R10]
               d.after_ack     = q.dir ? NX_TX_EVENT : NX_RX;
               d.ack_from_addr = 1'b1;
               d.sda_oe        = !ack_now; // see [R7]
               d.scl_oe        = 1'b0; // see [R5]
            end
            else if (cmd_wr && cmd == CMD_FINISH)
            begin
               d.state         = q.dir ? TS_IDLE : TS_ACK; // see [R9]
               d.after_ack     = NX_IDLE;
               d.ack_from_addr = 1'b1;
               d.sda_oe        = !q.dir && !ack_now;
               d.scl_oe        = 1'b0;
            end
         end
         TS_RX_HOLD:
         begin
            if ((cmd_wr && (cmd == CMD_RESPOND || cmd == CMD_FINISH)) ||
                (smart && data_rd))
            begin
               d.state         = TS_ACK; // see [R11]
               d.after_ack     = (cmd_wr && cmd == CMD_FINISH) ?
                                 NX_IDLE : NX_RX;
               d.ack_from_addr = 1'b0;
               d.sda_oe        = !ack_now; // see [R7]
               d.scl_oe        = 1'b0;
            end
         end
         TS_TX_HOLD:
         begin
            // writing the data register sends data, never an ack
            if ((cmd_wr && cmd == CMD_RESPOND) ||
                (smart && (data_rd || data_wr)))
            begin
               d.state   = TS_TX; // see [R11]
               d.shreg   = data_wr ? wbyte : q.data_reg;
               d.sda_oe  = data_wr ? !wbyte[7] : !q.data_reg[7];
               d.bit_cnt = 4'h0;
               d.scl_oe  = 1'b0;
            end
            else if (cmd_wr && cmd == CMD_FINISH)
            begin
               d.state  = TS_IDLE; // see [R9]
               d.scl_oe = 1'b0;
            end
         end
         default:
         begin
         end
      endcase

      // line protocol
      if (start_c)
      begin
         if (in_byte(q.state, q.bit_cnt) && q.ctrlr_en)
            d.illegal = 1'b1; // see [R20]
         d.conflict     = 1'b0; // see [R19]
         d.state        = TS_ADDR;
         d.bit_cnt      = 4'h0;
         d.just_started = 1'b1;
         d.sda_oe       = 1'b0;
         d.scl_oe       = 1'b0;
      end
      else if (stop_c)
      begin
         if ((q.just_started || in_byte(q.state, q.bit_cnt)) && q.ctrlr_en)
            d.illegal = 1'b1; // see [R20]
         if (q.ctrl[CTL_STOP_DET_EN] && q.state != TS_IDLE)
         begin
            d.addr_stop = 1'b1; // see [R3]
            d.cause     = CAUSE_STOP; // see [R22]
         end
         d.state        = TS_IDLE;
         d.just_started = 1'b0;
         d.sda_oe       = 1'b0;
         d.scl_oe       = 1'b0;
      end
      else
      begin
         if (rise)
            d.just_started = 1'b0;
         case (q.state)
            TS_ADDR, TS_RX:
            begin
               if (rise)
               begin
                  d.shreg   = {q.shreg[6:0], q.sda_s};
                  d.bit_cnt = q.bit_cnt + 4'h1;
               end
               else if (fall && q.bit_cnt == BYTE_BITS)
               begin
                  if (q.state == TS_RX)
                  begin
                     d.data_reg  = q.shreg;
                     d.byte_done = 1'b1; // see [R13]
                     d.scl_oe    = 1'b1; // see [R16]
                     d.state     = TS_RX_HOLD;
                  end
                  else if (addr_match(q.shreg[7:1], q.addr_reg,
                                      q.ctrl[CTL_PROMISC_EN])) // see [R4]
                  begin
                     d.dir       = q.shreg[0]; // see [R21]
                     d.addr_stop = 1'b1; // see [R15]
                     d.cause     = CAUSE_ADDR; // see [R22]
                     d.scl_oe    = 1'b1; // see [R16]
                     d.state     = TS_ADDR_HOLD;
                  end
                  else
                     d.state = TS_IDLE; // see [R24]
               end
            end
            TS_ACK:
            begin
               if (rise && !q.sda_oe && !q.sda_s && q.ack_from_addr)
                  d.conflict = 1'b1; // see [R18]
               if (fall)
               begin
                  d.sda_oe  = 1'b0;
                  d.bit_cnt = 4'h0;
                  if (q.after_ack == NX_IDLE || !q.sda_oe)
                     d.state = TS_IDLE;
                  else if (q.after_ack == NX_RX)
                     d.state = TS_RX; // see [R10]
                  else
                  begin
                     d.byte_done = 1'b1; // see [R10]
                     d.scl_oe    = 1'b1; // see [R16]
                     d.state     = TS_TX_HOLD;
                  end
               end
            end
            TS_TX:
            begin
               if (rise && !q.sda_oe && !q.sda_s)
               begin
                  // lost a high bit: abort and report the byte as done
                  d.conflict  = 1'b1; // see [R18]
                  d.byte_done = 1'b1; // see [R13]
                  d.state     = TS_IDLE;
                  d.sda_oe    = 1'b0;
               end
               else if (rise)
                  d.bit_cnt = q.bit_cnt + 4'h1;
               else if (fall && q.bit_cnt == BYTE_BITS)
               begin
                  d.sda_oe = 1'b0;
                  d.state  = TS_TX_ACK;
               end
               else if (fall)
               begin
                  d.shreg  = {q.shreg[6:0], 1'b0};
                  d.sda_oe = !q.shreg[6];
               end
            end
            TS_TX_ACK:
            begin
               if (rise)
                  d.last_ack = q.sda_s; // see [R17]
               else if (fall)
               begin
                  d.byte_done = 1'b1; // see [R13]
                  d.scl_oe    = 1'b1; // see [R16]
                  d.state     = TS_TX_HOLD;
               end
            end
            default:
            begin
            end
         endcase
      end

      // a disabled target leaves both lines alone
      if (!q.ctrl[CTL_ENABLE])
      begin
         d.state  = TS_IDLE; // see [R6]
         d.scl_oe = 1'b0;
         d.sda_oe = 1'b0;
      end

      // one flag and one line serve both address and stop events
      d.irq_as = q.ctrl[CTL_AS_IRQ_EN] && q.addr_stop &&
                 global_irq_en; // see [R1] [R2]
      d.irq_bd = q.ctrl[CTL_BYTE_IRQ_EN] && q.byte_done &&
                 global_irq_en; // see [R23]
   end

   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
      begin
         q        <= '0;
         q.state  <= TS_IDLE;
         q.scl_m  <= 1'b1;
         q.scl_s  <= 1'b1;
         q.scl_p  <= 1'b1;
         q.sda_m  <= 1'b1;
         q.sda_s  <= 1'b1;
         q.sda_p  <= 1'b1;
         q.wait_n <= 1'b1;
      end
      else
         q <= d;
   end

   assign readdata      = {24'h000000, q.rdata};
   assign waitrequest   = q.wait_n;
   assign scl_oe        = q.scl_oe;
   assign sda_oe        = q.sda_oe;
   assign irq_byte_done = q.irq_bd;
   assign irq_addr_stop = q.irq_as;

endmodule

// file: i2c_ctrl_model.sv
// behavioural bus controller that drives scl and sda as open drain
`timescale 1ns/1ps
module i2c_ctrl_model (
   input  wire logic scl,
   input  wire logic sda,
   output      logic scl_low,
   output      logic sda_low
);
   int stalls;

   initial
   begin
      scl_low = 1'b0;
      sda_low = 1'b0;
      stalls  = 0;
   end

   // the target may stretch, so a release waits for the line, bounded
   task automatic rise();
      int n;
      scl_low = 1'b0;
      n = 0;
      while (scl !== 1'b1 && n < 4000)
      begin
         #10;
         n++;
      end
      if (n == 4000)
         stalls++;
      #100;
   endtask

   task automatic start();
      sda_low = 1'b1;
      #200;
      scl_low = 1'b1;
      #100;
   endtask

   task automatic stop();
      sda_low = 1'b1;
      #100;
      rise();
      #100;
      sda_low = 1'b0;
      #200;
   endtask

   task automatic put_bit(input logic v);
      sda_low = ~v;
      #100;
      rise();
      #100;
      scl_low = 1'b1;
      #100;
   endtask

   task automatic get_bit(output logic v);
      sda_low = 1'b0;
      #100;
      rise();
      v = sda;
      #100;
      scl_low = 1'b1;
      #100;
   endtask

   task automatic put_byte(input logic [7:0] d);
      for (int i = 7; i >= 0; i--)
         put_bit(d[i]);
      sda_low = 1'b0;
   endtask

   task automatic get_byte(output logic [7:0] d);
      for (int i = 7; i >= 0; i--)
         get_bit(d[i]);
   endtask
endmodule

// file: i2c_target_asserts.sv
// port-level assertions for the i2c target, bound into its top module
`timescale 1ns/1ps
module i2c_target_asserts
   import i2c_target_pkg::*;
(
   input wire logic        clk,
   input wire logic        reset,
   input wire logic [5:0]  address,
   input wire logic        read,
   input wire logic        write,
   input wire logic [31:0] writedata,
   input wire logic [3:0]  byteenable,
   input wire logic [31:0] readdata,
   input wire logic        waitrequest,
   input wire logic        scl_oe,
   input wire logic        sda_oe,
   input wire logic        global_irq_en,
   input wire logic        irq_byte_done,
   input wire logic        irq_addr_stop
);
   localparam logic [5:0] A_CTL = {IDX_CONTROL, 2'b00};
   localparam logic [5:0] A_CMD = {IDX_CMD_CTRL, 2'b00};
   localparam logic [5:0] A_ST  = {IDX_STATUS, 2'b00};
   localparam logic [5:0] A_DAT = {IDX_DATA, 2'b00};
   logic [7:0] ctl_q;
   logic       as_en;
   logic       bd_en;

   // shadow of target_control, updated at the edge where the write lands
   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
         ctl_q <= 8'h00;
      else if (write && !waitrequest && address == A_CTL && byteenable[0])
         ctl_q <= writedata[7:0];
   end
   assign as_en = ctl_q[CTL_AS_IRQ_EN];
   assign bd_en = ctl_q[CTL_BYTE_IRQ_EN];

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (reset);

   sequence s_acc(a);
      (read || write) && !waitrequest && address == a;
   endsequence
   sequence s_cmd(c);
      write && !waitrequest && address == A_CMD && byteenable[0]
         && writedata[1:0] == c;
   endsequence

   a_as_irq_gate: assert property (
      irq_addr_stop |-> $past(global_irq_en) && $past(as_en))
      else $error("addr/stop irq raised without its enables");
   a_bd_irq_gate: assert property (
      irq_byte_done |-> $past(global_irq_en) && $past(bd_en))
      else $error("byte irq raised without its enables");
   a_cmd_reads_zero: assert property (
      s_acc(A_CMD) ##0 read |-> readdata[1:0] == 2'b00)
      else $error("command field read back nonzero");
   a_off_released: assert property (
      !ctl_q[CTL_ENABLE] [*3] |-> !scl_oe && !sda_oe)
      else $error("disabled target drives a line");
   a_stretch_status: assert property (
      s_acc(A_ST) ##0 (read && scl_oe == $past(scl_oe)
         && scl_oe == $past(scl_oe, 2)) |-> readdata[ST_STRETCH] == scl_oe)
      else $error("stretch status differs from scl hold");
   a_noop_keeps_hold: assert property (
      (s_cmd(CMD_RESERVED) or s_cmd(CMD_IDLE)) ##0 scl_oe
         |=> $stable(scl_oe) [*4])
      else $error("idle or reserved command changed hold");
   a_manual_hold: assert property (
      s_acc(A_DAT) ##0 (!ctl_q[CTL_AUTO_ACK_EN] && scl_oe) |=> scl_oe [*4])
      else $error("data access released hold without auto-ack");
   a_respond_release: assert property (
      s_cmd(CMD_RESPOND) ##0 scl_oe |-> ##[1:8] !scl_oe)
      else $error("respond command did not release scl");
   a_finish_release: assert property (
      s_cmd(CMD_FINISH) ##0 scl_oe |-> ##[1:8] !scl_oe)
      else $error("finish command did not release scl");
endmodule

bind i2c_target i2c_target_asserts u_asserts (
   .clk(clk), .reset(reset), .address(address), .read(read),
   .write(write), .writedata(writedata), .byteenable(byteenable),
   .readdata(readdata), .waitrequest(waitrequest), .scl_oe(scl_oe),
   .sda_oe(sda_oe), .global_irq_en(global_irq_en),
   .irq_byte_done(irq_byte_done), .irq_addr_stop(irq_addr_stop)
);

// file: i2c_target_tb.sv
// self-checking bench: register bus plus bus transactions on the target
`timescale 1ns/1ps
module i2c_target_tb
   import i2c_target_pkg::*;
;
   localparam logic [5:0] A_CC  = {IDX_CTRLR_CTRL, 2'b00};
   localparam logic [5:0] A_CTL = {IDX_CONTROL, 2'b00};
   localparam logic [5:0] A_CMD = {IDX_CMD_CTRL, 2'b00};
   localparam logic [5:0] A_ST  = {IDX_STATUS, 2'b00};
   localparam logic [5:0] A_ADR = {IDX_ADDRESS, 2'b00};
   localparam logic [5:0] A_DAT = {IDX_DATA, 2'b00};
   localparam logic [5:0] A_BAD = 6'h3c;
   logic        clk;
   logic        reset;
   logic [5:0]  address;
   logic        read;
   logic        write;
   logic [31:0] writedata;
   logic [3:0]  byteenable;
   logic [31:0] readdata;
   logic        waitrequest;
   logic        scl_oe;
   logic        sda_oe;
   logic        global_irq_en;
   logic        irq_byte_done;
   logic        irq_addr_stop;
   logic        scl_low;
   logic        sda_low;
   logic        scl;
   logic        sda;
   logic        b;
   logic [7:0]  q;
   int          errors;
   int          n_compared;

   // both lines pulled up; whoever pulls low wins
   assign scl = !(scl_low || scl_oe);
   assign sda = !(sda_low || sda_oe);

   i2c_target u_dut (
      .clk(clk), .reset(reset), .address(address), .read(read),
      .write(write), .writedata(writedata), .byteenable(byteenable),
      .readdata(readdata), .waitrequest(waitrequest), .scl_in(scl),
      .sda_in(sda), .scl_oe(scl_oe), .sda_oe(sda_oe),
      .global_irq_en(global_irq_en), .irq_byte_done(irq_byte_done),
      .irq_addr_stop(irq_addr_stop)
   );
   i2c_ctrl_model u_m (
      .scl(scl), .sda(sda), .scl_low(scl_low), .sda_low(sda_low)
   );

   initial
   begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end

   task automatic results();
      if (errors == 0 && n_compared > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   task automatic check(input string what, input logic [7:0] seen,
                        input logic [7:0] exp);
      n_compared++;
      if (seen !== exp)
      begin
         errors++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic bus(input logic wr, input logic [5:0] a,
                      input logic [7:0] d, output logic [7:0] v);
      int n;
      @(posedge clk);
      address   <= a;
      read      <= !wr;
      write     <= wr;
      writedata <= {24'h0, d};
      n = 0;
      @(posedge clk);
      while (waitrequest !== 1'b0 && n < 50)
      begin
         @(posedge clk);
         n++;
      end
      v = readdata[7:0];
      read  <= 1'b0;
      write <= 1'b0;
      if (n == 50)
      begin
         errors++;
         results();
      end
      // step off the edge so link events never race the clock
      #5;
   endtask

   task automatic wr(input logic [5:0] a, input logic [7:0] d);
      bus(1'b1, a, d, q);
   endtask

   task automatic rd(input string what, input logic [5:0] a,
                     input logic [7:0] m, input logic [7:0] e);
      bus(1'b0, a, 8'h00, q);
      check(what, q & m, e);
   endtask

   task automatic t_reset();
      rd("status", A_ST, 8'hff, 8'h00);
      rd("command", A_CMD, 8'hff, 8'h00);
      wr(A_BAD, 8'hff);
      rd("unmapped", A_BAD, 8'hff, 8'h00);
      byteenable <= 4'he;
      wr(A_ADR, 8'h11);
      byteenable <= 4'h1;
      rd("lane0 off", A_ADR, 8'hff, 8'h00);
      wr(A_CTL, 8'hff);
      rd("control", A_CTL, 8'hff, 8'he7);
   endtask

   task automatic t_write();
      wr(A_ADR, 8'h54);
      wr(A_CTL, 8'he1);
      u_m.start();
      u_m.put_byte(8'h54);
      rd("addr event", A_ST, 8'hff, 8'h61);
      check("as irq", {7'h0, irq_addr_stop}, 8'h01);
      global_irq_en <= 1'b0;
      repeat (3) @(posedge clk);
      check("as irq masked", {7'h0, irq_addr_stop}, 8'h00);
      global_irq_en <= 1'b1;
      wr(A_CMD, 8'h01);
      rd("reserved cmd", A_ST, 8'hff, 8'h61);
      wr(A_CMD, 8'h03);
      rd("after respond", A_ST, 8'he0, 8'h00);
      u_m.get_bit(b);
      check("addr ack", {7'h0, b}, 8'h00);
      u_m.put_byte(8'ha5);
      rd("rx event", A_ST, 8'he2, 8'ha0);
      check("bd irq", {7'h0, irq_byte_done}, 8'h01);
      rd("rx data", A_DAT, 8'hff, 8'ha5);
      rd("manual hold", A_ST, 8'he0, 8'h20);
      wr(A_CMD, 8'h03);
      u_m.get_bit(b);
      check("data ack", {7'h0, b}, 8'h00);
      u_m.stop();
      rd("stop event", A_ST, 8'h41, 8'h40);
   endtask

   task automatic t_read();
      u_m.start();
      u_m.put_byte(8'h55);
      rd("read addr", A_ST, 8'he3, 8'h63);
      wr(A_CMD, 8'h03);
      u_m.get_bit(b);
      check("read ack", {7'h0, b}, 8'h00);
      rd("tx event", A_ST, 8'he0, 8'ha0);
      wr(A_DAT, 8'h3c);
      rd("tx hold", A_ST, 8'he0, 8'h20);
      wr(A_CMD, 8'h03);
      u_m.get_byte(q);
      check("tx data", q, 8'h3c);
      u_m.put_bit(1'b1);
      rd("tx nack", A_ST, 8'hf0, 8'hb0);
      wr(A_CMD, 8'h02);
      rd("finish", A_ST, 8'he0, 8'h00);
      u_m.stop();
   endtask

   task automatic t_match();
      u_m.start();
      u_m.put_byte(8'h56);
      u_m.get_bit(b);
      check("no match nack", {7'h0, b}, 8'h01);
      rd("no match", A_ST, 8'he0, 8'h00);
      u_m.stop();
      wr(A_CTL, 8'h67);
      u_m.start();
      u_m.put_byte(8'h56);
      rd("promiscuous", A_ST, 8'h41, 8'h41);
      wr(A_CMD, 8'h07);
      u_m.get_bit(b);
      check("nack select", {7'h0, b}, 8'h01);
      u_m.stop();
      u_m.start();
      u_m.put_byte(8'h56);
      wr(A_CMD, 8'h00);
      rd("idle cmd", A_ST, 8'h60, 8'h60);
      rd("smart data", A_DAT, 8'hff, 8'h3c);
      rd("smart resume", A_ST, 8'he0, 8'h00);
      u_m.get_bit(b);
      check("smart ack", {7'h0, b}, 8'h00);
      u_m.stop();
   endtask

   task automatic t_err_off();
      wr(A_CC, 8'h01);
      u_m.start();
      u_m.stop();
      rd("bus error", A_ST, 8'h04, 8'h04);
      wr(A_ST, 8'h04);
      rd("error cleared", A_ST, 8'h04, 8'h00);
      wr(A_CTL, 8'h00);
      u_m.start();
      u_m.put_byte(8'h54);
      u_m.get_bit(b);
      check("disabled nack", {7'h0, b}, 8'h01);
      rd("disabled", A_ST, 8'ha0, 8'h00);
      u_m.stop();
   endtask

   initial
   begin
      reset         = 1'b1;
      address       = 6'h00;
      read          = 1'b0;
      write         = 1'b0;
      writedata     = 32'h0;
      byteenable    = 4'h1;
      global_irq_en = 1'b1;
      errors        = 0;
      n_compared    = 0;
      repeat (6) @(posedge clk);
      reset <= 1'b0;
      t_reset();
      t_write();
      t_read();
      t_match();
      t_err_off();
      check("scl stall", {7'h0, u_m.stalls != 0}, 8'h00);
      results();
   end
endmodule
